// file: pkg/mrmd_cfg.svh
// offsets, field positions and encodings of the register move decoder
`ifndef MRMD_CFG_SVH
`define MRMD_CFG_SVH

// ----------------------------------------
// apb register offsets
// ----------------------------------------
`define MRMD_OFF_CTRL 8'h00
`define MRMD_OFF_CMD 8'h04
`define MRMD_OFF_OPLO 8'h08
`define MRMD_OFF_OPHI 8'h0C
`define MRMD_OFF_CODES 8'h10
`define MRMD_OFF_STATUS 8'h14
`define MRMD_OFF_RESLO 8'h18
`define MRMD_OFF_RESHI 8'h1C

// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define MRMD_OP_PREFIX 10'h3C0
`define MRMD_CLS_WIN 3'h0
`define MRMD_CLS_PRELOAD 3'h1
`define MRMD_CLS_RPTC 3'h2
`define MRMD_CLS_STAT 3'h3
`define MRMD_PR_TC 3'h0
`define MRMD_PR_DRP 3'h1
`define MRMD_PR_SRP 3'h2
`define MRMD_PR_CRP 3'h3
`define MRMD_PR_CAL 3'h4
`define MRMD_PR_VAL 3'h5
`define MRMD_PR_SCC 3'h6
`define MRMD_PR_ACR 3'h7
`define MRMD_PR_WIN0 3'h2
`define MRMD_PR_WIN1 3'h3
`define MRMD_PR_ACW0 3'h1
`define MRMD_PR_ACW1 3'h3
`define MRMD_PR_PSR 3'h0
`define MRMD_PR_MMU_CACHE_STATUS 3'h1
`define MRMD_PR_BAD 3'h4
`define MRMD_PR_BAC 3'h5

// ----------------------------------------
// effective address modes
// ----------------------------------------
`define MRMD_EA_DN 3'h0
`define MRMD_EA_AN 3'h1
`define MRMD_EA_IND 3'h2
`define MRMD_EA_DISP 3'h5
`define MRMD_EA_IDX 3'h6
`define MRMD_EA_EXT 3'h7
`define MRMD_EA_ABSW 3'h0
`define MRMD_EA_ABSL 3'h1
`define MRMD_EA_PCD 3'h2
`define MRMD_EA_PCX 3'h3
`define MRMD_EA_IMM 3'h4

// ----------------------------------------
// register fields and checks
// ----------------------------------------
`define MRMD_TC_E 31
`define MRMD_WIN_E 15
`define MRMD_RP_DT_BAD 2'h0
`define MRMD_TC_SUM 7'h20
`define MRMD_PS_MIN 4'h8
`define MRMD_RPT_DEPTH 8
`define MRMD_BRK_DEPTH 8

`endif

// file: pkg/mrmd_pkg.sv
// types shared by the register move decoder
`include "mrmd_cfg.svh"
package mrmd_pkg;

	typedef enum logic [1:0] {
		VAR_COPROC = 2'h0,
		VAR_INTEG = 2'h1,
		VAR_EMBED = 2'h2
	} mrmd_variant_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} mrmd_fsm_e;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2,
		SZ_QUAD = 2'h3
	} mrmd_size_e;

	typedef enum logic [4:0] {
		T_NONE, T_PRELOAD, T_TC, T_SRP, T_CRP, T_DRP, T_WIN0, T_WIN1, T_STAT,
		T_MMU_CACHE_STATUS, T_CAL, T_VAL, T_SCC, T_ACR, T_BAC, T_BAD
	} mrmd_target_e;

	typedef struct packed {
		mrmd_fsm_e state;
		mrmd_variant_e variant;
		logic [15:0] opWord;
		logic [15:0] cmdWord;
		logic [31:0] opLo;
		logic [31:0] opHi;
		logic [2:0] source_function_code;
		logic [2:0] dfc;
		logic [3:0] dregFc;
		logic [63:0] cpu_root_pointer;
		logic [63:0] supervisor_root_pointer;
		logic [63:0] dma_root_pointer;
		logic [31:0] tc;
		logic [1:0][31:0] win;
		logic [15:0] mmuStat;
		logic [15:0] mmu_cache_status;
		logic [15:0] acr;
		logic [7:0] cal;
		logic [7:0] val;
		logic [7:0] stack_change_control;
		logic [`MRMD_BRK_DEPTH-1:0][15:0] bac;
		logic [`MRMD_BRK_DEPTH-1:0][15:0] bad;
		logic [`MRMD_RPT_DEPTH-1:0][63:0] rpt;
		logic [`MRMD_RPT_DEPTH-1:0] rptValid;
		logic [2:0] rptNext;
		logic [31:0] resLo;
		logic [31:0] resHi;
		mrmd_size_e size;
		logic done;
		logic illegal;
		logic cfgErr;
		logic flushed;
		logic flushAll;
		logic invSup;
		logic invDma;
		logic rptInval;
		logic [2:0] rptIdx;
		logic preloadStb;
		logic preloadRead;
		logic [3:0] preloadFc;
		logic [31:0] preloadAddr;
		logic cfgPulse;
		logic illegalPulse;
		logic [31:0] prdata;
	} mrmd_state_s;

endpackage

// file: rtl/mrmd_fc_select.sv
// function code field decode for the translation preload operation
`timescale 1ns/1ps
module mrmd_fc_select (
	input wire mrmd_pkg::mrmd_variant_e variant,
	input wire logic [4:0] fcField,
	input wire logic [2:0] source_function_code,
	input wire logic [2:0] dfc,
	input wire logic [3:0] dregFc,
	output logic [3:0] fc,
	output logic fcOk
);

	always_comb begin
		fc = 4'h0;
		fcOk = 1'b0;
		if (fcField == 5'h00) begin
			fc = {1'b0, source_function_code};
			fcOk = 1'b1;
		end else if (fcField == 5'h01) begin
			fc = {1'b0, dfc};
			fcOk = 1'b1;
		end else if (fcField[4:3] == 2'b01) begin
			fcOk = 1'b1;
			if (variant == mrmd_pkg::VAR_COPROC) begin
				fc = dregFc;
			end else begin
				fc = {1'b0, dregFc[2:0]};
			end
		end else if (fcField[4]) begin
			if (variant == mrmd_pkg::VAR_COPROC) begin
				fc = fcField[3:0];
				fcOk = 1'b1;
			end else if (!fcField[3]) begin
				fc = {1'b0, fcField[2:0]};
				fcOk = 1'b1;
			end
		end
	end

endmodule // mrmd_fc_select

// file: rtl/mrmd_top.sv
// memory management register move and translation preload decoder
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "mrmd_cfg.svh"

module mrmd_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic atcFlushAll,
	output logic atcInvalidSupervisor,
	output logic atcInvalidDma,
	output logic rptInvalidate,
	output logic [2:0] rptIndex,
	output logic preloadStrobe,
	output logic preloadRead,
	output logic [3:0] preloadFc,
	output logic [31:0] preloadAddr,
	output logic configError,
	output logic illegalInstr,
	output logic [1:0] windowEnable
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic eaCtrlAlt(input logic [2:0] mode, input logic [2:0] reg3);
		return (mode == `MRMD_EA_IND) || (mode == `MRMD_EA_DISP) || (mode == `MRMD_EA_IDX)
			|| ((mode == `MRMD_EA_EXT) && ((reg3 == `MRMD_EA_ABSW) || (reg3 == `MRMD_EA_ABSL)));
	endfunction

	function automatic logic eaCoproc(input logic [2:0] mode, input logic [2:0] reg3,
			input logic outward, input logic rootPtr);
		logic ok;
		ok = 1'b1;
		if (mode == `MRMD_EA_EXT) begin
			ok = (reg3 == `MRMD_EA_ABSW) || (reg3 == `MRMD_EA_ABSL)
				|| (!outward && ((reg3 == `MRMD_EA_IMM) || (reg3 == `MRMD_EA_PCD)
				|| (reg3 == `MRMD_EA_PCX)));
		end else if ((mode == `MRMD_EA_DN) || (mode == `MRMD_EA_AN)) begin
			ok = !rootPtr;
		end
		return ok;
	endfunction

	function automatic logic tcConsistent(input logic [31:0] v);
		logic [6:0] sum;
		logic stop;
		sum = 7'(v[23:20]) + 7'(v[19:16]);
		stop = 1'b0;
		for (int k = 3; k >= 0; k--) begin
			if (v[k*4 +: 4] == 4'h0) begin
				stop = 1'b1;
			end
			if (!stop) begin
				sum = sum + 7'(v[k*4 +: 4]);
			end
		end
		return (sum == `MRMD_TC_SUM) && (v[23:20] >= `MRMD_PS_MIN);
	endfunction

	function automatic logic addrMapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `MRMD_OFF_RESHI);
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	mrmd_pkg::mrmd_state_s st;
	mrmd_pkg::mrmd_state_s next_st;
	logic [3:0] fcVal;
	logic fcOk;
	logic [`MRMD_RPT_DEPTH-1:0] rptMatch;

	mrmd_fc_select fcSel (
		.variant(st.variant),
		.fcField(st.cmdWord[4:0]),
		.source_function_code(st.source_function_code),
		.dfc(st.dfc),
		.dregFc(st.dregFc),
		.fc(fcVal),
		.fcOk(fcOk)
	);

	genvar gi;
	generate
		for (gi = 0; gi < `MRMD_RPT_DEPTH; gi++) begin : gRpt
			assign rptMatch[gi] = st.rptValid[gi] && (st.rpt[gi] == {st.opHi, st.opLo});
		end
		for (gi = 0; gi < 2; gi++) begin : gWin
			assign windowEnable[gi] = st.win[gi][`MRMD_WIN_E];
		end
	endgenerate

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		mrmd_pkg::mrmd_target_e tgt;
		logic [2:0] cls;
		logic [2:0] preg;
		logic rw;
		logic fd;
		logic [2:0] mode;
		logic [2:0] eaReg;
		logic eaOk;
		logic isRp;
		logic integ;
		logic [63:0] quad;
		logic [2:0] brk;
		tgt = mrmd_pkg::T_NONE;
		cls = st.cmdWord[15:13];
		preg = st.cmdWord[12:10];
		rw = st.cmdWord[9];
		fd = st.cmdWord[8];
		mode = st.opWord[5:3];
		eaReg = st.opWord[2:0];
		eaOk = 1'b0;
		isRp = 1'b0;
		integ = (st.variant == mrmd_pkg::VAR_INTEG);
		quad = {st.opHi, st.opLo};
		brk = st.cmdWord[4:2];
		next_st = st;
		next_st.flushAll = 1'b0;
		next_st.invSup = 1'b0;
		next_st.invDma = 1'b0;
		next_st.rptInval = 1'b0;
		next_st.preloadStb = 1'b0;
		next_st.cfgPulse = 1'b0;
		next_st.illegalPulse = 1'b0;

		// apb read data, captured in the setup cycle
		if (psel && !penable && !pwrite) begin
			case (paddr)
				`MRMD_OFF_CTRL: next_st.prdata = {30'h0, st.variant};
				`MRMD_OFF_CMD: next_st.prdata = {st.opWord, st.cmdWord};
				`MRMD_OFF_OPLO: next_st.prdata = st.opLo;
				`MRMD_OFF_OPHI: next_st.prdata = st.opHi;
				`MRMD_OFF_CODES: next_st.prdata = {20'h0, st.dregFc, 1'b0, st.dfc, 1'b0, st.source_function_code};
				`MRMD_OFF_STATUS: next_st.prdata = {20'h0, st.preloadRead, st.preloadFc,
					st.flushed, st.size, st.cfgErr, st.illegal, st.done,
					st.state == mrmd_pkg::ST_EXEC};
				`MRMD_OFF_RESLO: next_st.prdata = st.resLo;
				`MRMD_OFF_RESHI: next_st.prdata = st.resHi;
				default: next_st.prdata = 32'h0;
			endcase
		end

		// apb writes
		if (psel && penable && pwrite) begin
			case (paddr)
				`MRMD_OFF_CTRL: next_st.variant = mrmd_pkg::mrmd_variant_e'(pwdata[1:0]);
				`MRMD_OFF_CMD: begin
					// a command issued while one executes is dropped
					if (st.state == mrmd_pkg::ST_IDLE) begin
						next_st.opWord = pwdata[31:16];
						next_st.cmdWord = pwdata[15:0];
						next_st.state = mrmd_pkg::ST_EXEC;
						next_st.done = 1'b0;
						next_st.illegal = 1'b0;
						next_st.cfgErr = 1'b0;
						next_st.flushed = 1'b0;
					end
				end
				`MRMD_OFF_OPLO: next_st.opLo = pwdata;
				`MRMD_OFF_OPHI: next_st.opHi = pwdata;
				`MRMD_OFF_CODES: begin
					next_st.source_function_code = pwdata[2:0];
					next_st.dfc = pwdata[6:4];
					next_st.dregFc = pwdata[11:8];
				end
				default: ;
			endcase
		end

		// instruction decode
		case (st.variant)
			mrmd_pkg::VAR_INTEG: begin
				case (cls)
					`MRMD_CLS_PRELOAD: if (preg == 3'h0 && st.cmdWord[8:5] == 4'h0)
						tgt = mrmd_pkg::T_PRELOAD;
					`MRMD_CLS_RPTC: if (st.cmdWord[7:0] == 8'h00) begin
						case (preg)
							`MRMD_PR_TC: tgt = mrmd_pkg::T_TC;
							`MRMD_PR_SRP: tgt = mrmd_pkg::T_SRP;
							`MRMD_PR_CRP: tgt = mrmd_pkg::T_CRP;
							default: tgt = mrmd_pkg::T_NONE;
						endcase
					end
					`MRMD_CLS_STAT: if (preg == `MRMD_PR_PSR && st.cmdWord[8:0] == 9'h000)
						tgt = mrmd_pkg::T_STAT;
					`MRMD_CLS_WIN: if (st.cmdWord[7:0] == 8'h00) begin
						case (preg)
							`MRMD_PR_WIN0: tgt = mrmd_pkg::T_WIN0;
							`MRMD_PR_WIN1: tgt = mrmd_pkg::T_WIN1;
							default: tgt = mrmd_pkg::T_NONE;
						endcase
					end
					default: tgt = mrmd_pkg::T_NONE;
				endcase
			end
			mrmd_pkg::VAR_EMBED: begin
				if (st.cmdWord[8:0] == 9'h000) begin
					if (cls == `MRMD_CLS_STAT && preg == `MRMD_PR_PSR) begin
						tgt = mrmd_pkg::T_STAT;
					end else if (cls == `MRMD_CLS_WIN && preg == `MRMD_PR_ACW0) begin
						tgt = mrmd_pkg::T_WIN0;
					end else if (cls == `MRMD_CLS_WIN && preg == `MRMD_PR_ACW1) begin
						tgt = mrmd_pkg::T_WIN1;
					end
				end
			end
			mrmd_pkg::VAR_COPROC: begin
				case (cls)
					`MRMD_CLS_PRELOAD: if (preg == 3'h0 && st.cmdWord[8:5] == 4'h0)
						tgt = mrmd_pkg::T_PRELOAD;
					`MRMD_CLS_RPTC: if (st.cmdWord[8:0] == 9'h000) begin
						case (preg)
							`MRMD_PR_TC: tgt = mrmd_pkg::T_TC;
							`MRMD_PR_DRP: tgt = mrmd_pkg::T_DRP;
							`MRMD_PR_SRP: tgt = mrmd_pkg::T_SRP;
							`MRMD_PR_CRP: tgt = mrmd_pkg::T_CRP;
							`MRMD_PR_CAL: tgt = mrmd_pkg::T_CAL;
							`MRMD_PR_VAL: tgt = mrmd_pkg::T_VAL;
							`MRMD_PR_SCC: tgt = mrmd_pkg::T_SCC;
							default: tgt = mrmd_pkg::T_ACR;
						endcase
					end
					`MRMD_CLS_STAT: if (st.cmdWord[8:5] == 4'h0) begin
						if (preg == `MRMD_PR_PSR && st.cmdWord[4:0] == 5'h00) begin
							tgt = mrmd_pkg::T_STAT;
						end else if (preg == `MRMD_PR_MMU_CACHE_STATUS && rw && st.cmdWord[4:0] == 5'h00) begin
							tgt = mrmd_pkg::T_MMU_CACHE_STATUS;
						end else if (preg == `MRMD_PR_BAD && st.cmdWord[1:0] == 2'h0) begin
							tgt = mrmd_pkg::T_BAD;
						end else if (preg == `MRMD_PR_BAC && st.cmdWord[1:0] == 2'h0) begin
							tgt = mrmd_pkg::T_BAC;
						end
					end
					default: tgt = mrmd_pkg::T_NONE;
				endcase
			end
			default: tgt = mrmd_pkg::T_NONE;
		endcase

		isRp = (tgt == mrmd_pkg::T_CRP) || (tgt == mrmd_pkg::T_SRP) || (tgt == mrmd_pkg::T_DRP);
		if (st.variant == mrmd_pkg::VAR_COPROC && tgt != mrmd_pkg::T_PRELOAD) begin
			eaOk = eaCoproc(mode, eaReg, rw, isRp);
		end else begin
			eaOk = eaCtrlAlt(mode, eaReg);
		end

		// execution, one cycle after the command write
		if (st.state == mrmd_pkg::ST_EXEC) begin
			next_st.state = mrmd_pkg::ST_IDLE;
			next_st.done = 1'b1;
			next_st.resLo = 32'h0;
			next_st.resHi = 32'h0;
			if (st.opWord[15:6] != `MRMD_OP_PREFIX || tgt == mrmd_pkg::T_NONE || !eaOk
				|| (tgt == mrmd_pkg::T_PRELOAD && !fcOk)) begin
				next_st.illegal = 1'b1;
				next_st.illegalPulse = 1'b1;
			end else begin
				case (tgt)
					mrmd_pkg::T_PRELOAD: begin
						next_st.preloadStb = 1'b1;
						next_st.preloadAddr = st.opLo;
						next_st.preloadRead = rw;
						next_st.preloadFc = fcVal;
					end
					mrmd_pkg::T_SRP, mrmd_pkg::T_CRP, mrmd_pkg::T_DRP: begin
						next_st.size = mrmd_pkg::SZ_QUAD;
						if (rw) begin
							{next_st.resHi, next_st.resLo} = (tgt == mrmd_pkg::T_SRP) ? st.supervisor_root_pointer :
								(tgt == mrmd_pkg::T_CRP) ? st.cpu_root_pointer : st.dma_root_pointer;
						end else begin
							if (tgt == mrmd_pkg::T_SRP) begin
								next_st.supervisor_root_pointer = quad;
							end else if (tgt == mrmd_pkg::T_CRP) begin
								next_st.cpu_root_pointer = quad;
							end else begin
								next_st.dma_root_pointer = quad;
							end
							if (integ) begin
								next_st.flushAll = !fd;
								next_st.flushed = !fd;
								if (st.opHi[1:0] == `MRMD_RP_DT_BAD) begin
									next_st.cfgErr = 1'b1;
									next_st.cfgPulse = 1'b1;
								end
							end else if (tgt == mrmd_pkg::T_SRP) begin
								next_st.invSup = 1'b1;
							end else if (tgt == mrmd_pkg::T_DRP) begin
								next_st.invDma = 1'b1;
							end else if (rptMatch == '0) begin
								next_st.rpt[st.rptNext] = quad;
								next_st.rptValid[st.rptNext] = 1'b1;
								next_st.rptInval = st.rptValid[st.rptNext];
								next_st.rptIdx = st.rptNext;
								next_st.rptNext = st.rptNext + 3'h1;
							end
						end
					end
					mrmd_pkg::T_TC: begin
						next_st.size = mrmd_pkg::SZ_LONG;
						if (rw) begin
							next_st.resLo = st.tc;
						end else begin
							next_st.tc = st.opLo;
							if (integ) begin
								next_st.flushAll = !fd;
								next_st.flushed = !fd;
								if (st.opLo[`MRMD_TC_E]) begin
									if (!tcConsistent(st.opLo)) begin
										next_st.cfgErr = 1'b1;
										next_st.cfgPulse = 1'b1;
									end else begin
										next_st.tc[`MRMD_TC_E] = 1'b0;
									end
								end
							end else if (st.opLo[`MRMD_TC_E] && !st.tc[`MRMD_TC_E]) begin
								if (!tcConsistent(st.opLo)) begin
									next_st.cfgErr = 1'b1;
									next_st.cfgPulse = 1'b1;
								end
							end
						end
					end
					mrmd_pkg::T_WIN0, mrmd_pkg::T_WIN1: begin
						next_st.size = mrmd_pkg::SZ_LONG;
						if (rw) begin
							next_st.resLo = st.win[tgt == mrmd_pkg::T_WIN1];
						end else begin
							next_st.win[tgt == mrmd_pkg::T_WIN1] = st.opLo;
							next_st.flushAll = integ && !fd;
							next_st.flushed = integ && !fd;
						end
					end
					mrmd_pkg::T_STAT: begin
						next_st.size = mrmd_pkg::SZ_WORD;
						if (rw) begin
							next_st.resLo = {16'h0, st.mmuStat};
						end else begin
							next_st.mmuStat = st.opLo[15:0];
						end
					end
					mrmd_pkg::T_MMU_CACHE_STATUS: begin
						next_st.size = mrmd_pkg::SZ_WORD;
						next_st.resLo = {16'h0, st.mmu_cache_status};
					end
					mrmd_pkg::T_ACR, mrmd_pkg::T_BAC, mrmd_pkg::T_BAD: begin
						next_st.size = mrmd_pkg::SZ_WORD;
						if (rw) begin
							next_st.resLo = {16'h0, (tgt == mrmd_pkg::T_ACR) ? st.acr :
								(tgt == mrmd_pkg::T_BAC) ? st.bac[brk] : st.bad[brk]};
						end else if (tgt == mrmd_pkg::T_ACR) begin
							next_st.acr = st.opLo[15:0];
						end else if (tgt == mrmd_pkg::T_BAC) begin
							next_st.bac[brk] = st.opLo[15:0];
						end else begin
							next_st.bad[brk] = st.opLo[15:0];
						end
					end
					default: begin
						next_st.size = mrmd_pkg::SZ_BYTE;
						if (rw) begin
							next_st.resLo = {24'h0, (tgt == mrmd_pkg::T_CAL) ? st.cal :
								(tgt == mrmd_pkg::T_VAL) ? st.val : st.stack_change_control};
						end else if (tgt == mrmd_pkg::T_CAL) begin
							next_st.cal = st.opLo[7:0];
						end else if (tgt == mrmd_pkg::T_VAL) begin
							next_st.val = st.opLo[7:0];
						end else begin
							next_st.stack_change_control = st.opLo[7:0];
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
			st.state <= mrmd_pkg::ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata = st.prdata;
	// zero wait states keep the access phase one cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addrMapped(paddr);
	assign atcFlushAll = st.flushAll;
	assign atcInvalidSupervisor = st.invSup;
	assign atcInvalidDma = st.invDma;
	assign rptInvalidate = st.rptInval;
	assign rptIndex = st.rptIdx;
	assign preloadStrobe = st.preloadStb;
	assign preloadRead = st.preloadRead;
	assign preloadFc = st.preloadFc;
	assign preloadAddr = st.preloadAddr;
	assign configError = st.cfgPulse;
	assign illegalInstr = st.illegalPulse;

endmodule // mrmd_top

// file: verification/mrmd_monitor.sv
// port checks for the register move decoder
`timescale 1ns/1ps
`include "mrmd_cfg.svh"
module mrmd_monitor (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic atcFlushAll,
	input wire logic atcInvalidSupervisor,
	input wire logic atcInvalidDma,
	input wire logic rptInvalidate,
	input wire logic preloadStrobe,
	input wire logic [3:0] preloadFc,
	input wire logic [31:0] preloadAddr,
	input wire logic configError,
	input wire logic illegalInstr,
	input wire logic [1:0] windowEnable
);
	logic cmdHit;
	logic anyPulse;
	assign cmdHit = psel && penable && pwrite && paddr == `MRMD_OFF_CMD;
	assign anyPulse = atcFlushAll || atcInvalidSupervisor || atcInvalidDma || rptInvalidate
		|| preloadStrobe || configError || illegalInstr;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// ---
	// command steps
	// ---
	sequence cmdWr;
		cmdHit;
	endsequence
	sequence illegalRun;
		cmdWr ##2 illegalInstr;
	endsequence
	zero_wait_a: assert property (psel && penable |-> pready)
		else $error("access phase waited");
	unmapped_error_a: assert property (pslverr == (psel && penable
		&& (paddr[1:0] != 2'h0 || paddr > 8'h1C))) else $error("pslverr wrong");
	// taken at one edge, executed at the next, seen at the one after
	effect_cause_a: assert property (anyPulse |-> $past(cmdHit, 2))
		else $error("effect without command");
	pulse_single_a: assert property (anyPulse |=> !anyPulse)
		else $error("effect pulse too long");
	illegal_quiet_a: assert property (illegalRun |-> !atcFlushAll && !configError
		&& !preloadStrobe && !rptInvalidate && $stable(windowEnable))
		else $error("illegal command changed state");
	window_hold_a: assert property ($changed(windowEnable) |-> $past(cmdHit, 2))
		else $error("window enable moved alone");
	preload_hold_a: assert property ($changed(preloadAddr) || $changed(preloadFc)
		|-> preloadStrobe) else $error("preload fields moved alone");
	effect_exclusive_a: assert property ($onehot0({atcFlushAll, atcInvalidSupervisor,
		atcInvalidDma, preloadStrobe, illegalInstr})) else $error("effects overlap");
endmodule // mrmd_monitor

// file: verification/mrmd_cpu_model.sv
// bus master standing in for the integer unit
`timescale 1ns/1ps
module mrmd_cpu_model (
	input wire logic clk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [7:0] paddr = 8'h00,
	output logic [31:0] pwdata = 32'h0
);
	// bounded wait so a stuck slave ends the run
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e, output logic ok);
		ok = 1'b0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		repeat (16) if (!ok) begin
			@(posedge clk);
			ok = pready === 1'b1;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // mrmd_cpu_model

// file: verification/test_mmu_register_move_decode.sv
// bench for the register move decoder
`timescale 1ns/1ps
`include "mrmd_cfg.svh"
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin nErrors++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_mmu_register_move_decode;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, atcFlushAll, atcInvalidSupervisor, err;
	logic atcInvalidDma, rptInvalidate, preloadStrobe, preloadRead, configError, illegalInstr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, preloadAddr, q, rnd = 32'h47;
	logic [2:0] rptIndex;
	logic [3:0] preloadFc;
	logic [1:0] windowEnable, winExp;
	logic [5:0] ea [4] = '{6'h10, 6'h28, 6'h30, 6'h39};
	logic [5:0] bad [5] = '{6'h00, 6'h08, 6'h18, 6'h20, 6'h3C};
	logic [4:0] f;
	int nErrors = 0;
	int cmpCount = 0;
	int i;
	int k;
	always #5 clk = ~clk;
	mrmd_cpu_model cpu (.clk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
	mrmd_top dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .atcFlushAll, .atcInvalidSupervisor, .atcInvalidDma, .rptInvalidate, .rptIndex,
		.preloadStrobe, .preloadRead, .preloadFc, .preloadAddr, .configError, .illegalInstr,
		.windowEnable);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [3:0] fcExp(input logic integ, input logic [4:0] f, input logic [11:0] c);
		if (f == 5'h00) return {1'b0, c[2:0]};
		if (f == 5'h01) return {1'b0, c[6:4]};
		if (f[4:3] == 2'b01) return integ ? {1'b0, c[10:8]} : c[11:8];
		return integ ? {1'b0, f[2:0]} : f[3:0];
	endfunction
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmpCount, nErrors);
		if (nErrors == 0 && cmpCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic ok;
		cpu.xfer(w, a, d, q, err, ok);
		if (!ok) begin
			nErrors++;
			print_verdict();
		end
	endtask
	// effects are sampled one cycle after the command write
	task automatic exec(input logic [1:0] v, input logic [5:0] m, input logic [15:0] cw);
		apb(1'b1, `MRMD_OFF_CTRL, {30'h0, v});
		apb(1'b1, `MRMD_OFF_CMD, {10'h3C0, m, cw});
		@(posedge clk);
		#1;
	endtask
	task automatic size(input logic [1:0] s);
		apb(1'b0, `MRMD_OFF_STATUS, 32'h0);
		`CHK("size", s, q[5:4])
	endtask
	task automatic tcCase(input logic [1:0] v, input logic [31:0] d, input logic c, input logic [31:0] r);
		apb(1'b1, `MRMD_OFF_OPLO, d);
		exec(v, ea[1], 16'h4000);
		`CHK("tcCfg", c, configError)
		exec(v, ea[2], 16'h4200);
		apb(1'b0, `MRMD_OFF_RESLO, 32'h0);
		`CHK("tcOut", r, q)
	endtask
	initial begin
		winExp = 2'h0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, 8'h20, 32'h0);
		`CHK("slverr", 1'b1, err)
		apb(1'b0, `MRMD_OFF_RESHI, 32'h0);
		`CHK("slverr", 1'b0, err)
		// odd passes run the embedded variant, which never flushes
		for (i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			k = 1 + i % 2;
			apb(1'b1, `MRMD_OFF_OPLO, rnd);
			exec(k[1:0], ea[i % 4], {3'h0, (k == 1 ? {2'b01, rnd[16]} : {rnd[16], 1'b1}),
				1'b0, k == 1 && rnd[17], 8'h00});
			winExp[rnd[16]] = rnd[15];
			`CHK("flush", k == 1 && !rnd[17], atcFlushAll)
			`CHK("winEn", winExp, windowEnable)
			size(2'h2);
		end
		foreach (bad[j]) begin
			exec(2'h1, bad[j], 16'h0800);
			`CHK("illegal", 1'b1, illegalInstr)
			`CHK("winKeep", winExp, windowEnable)
		end
		exec(2'h1, ea[0], 16'h4400);
		`CHK("badSel", 1'b1, illegalInstr)
		$display("done windows");
		for (i = 0; i < 4; i++) begin
			apb(1'b1, `MRMD_OFF_OPHI, {30'h0, i[0], 1'b0});
			exec(2'h1, ea[i], {3'h2, 2'b01, i[1], 2'b01, 8'h00});
			`CHK("cfgErr", !i[0], configError)
			`CHK("fdKeep", 1'b0, atcFlushAll)
			size(2'h3);
		end
		tcCase(2'h1, 32'h8080CC00, 1'b0, 32'h0080CC00);
		tcCase(2'h1, 32'h80801000, 1'b1, 32'h80801000);
		tcCase(2'h0, 32'h0, 1'b0, 32'h0);
		tcCase(2'h0, 32'h80801000, 1'b1, 32'h80801000);
		tcCase(2'h0, 32'h80801000, 1'b0, 32'h80801000);
		// status word moves as destination and as source, and never flushes
		apb(1'b1, `MRMD_OFF_OPLO, 32'h1234A5C3);
		exec(2'h1, ea[1], 16'h6000);
		`CHK("stFlush", 1'b0, atcFlushAll)
		size(2'h1);
		exec(2'h1, ea[2], 16'h0800);
		exec(2'h2, ea[3], 16'h6200);
		apb(1'b0, `MRMD_OFF_RESLO, 32'h0);
		`CHK("status", 32'h0000A5C3, q)
		$display("done control");
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			k = i / 4;
			apb(1'b1, `MRMD_OFF_OPLO, rnd);
			apb(1'b1, `MRMD_OFF_CODES, {20'h0, rnd[11:0]});
			case (i % 4)
				0: f = k ? {1'b1, rnd[3:0]} : {2'b10, rnd[2:0]};
				1: f = {2'b01, rnd[2:0]};
				default: f = {4'h0, i[0]};
			endcase
			exec(k ? 2'h0 : 2'h1, ea[i % 4], {6'h08, rnd[20], 4'h0, f});
			`CHK("plAddr", rnd, preloadAddr)
			`CHK("plRead", rnd[20], preloadRead)
			`CHK("plFc", fcExp(k == 0, f, rnd[11:0]), preloadFc)
		end
		$display("done preload");
		apb(1'b1, `MRMD_OFF_OPHI, 32'h2);
		exec(2'h0, ea[0], 16'h4800);
		`CHK("invSup", 1'b1, atcInvalidSupervisor)
		exec(2'h0, ea[0], 16'h4400);
		`CHK("invDma", 1'b1, atcInvalidDma)
		exec(2'h0, 6'h00, 16'h4C00);
		`CHK("dnRoot", 1'b1, illegalInstr)
		exec(2'h0, 6'h00, 16'h5000);
		`CHK("dnCal", 1'b0, illegalInstr)
		size(2'h0);
		for (i = 0; i < 10; i++) begin
			apb(1'b1, `MRMD_OFF_OPLO, i < 9 ? i : 8);
			exec(2'h0, ea[3], 16'h4C00);
			`CHK("rptInv", i == 8, rptInvalidate)
			`CHK("rptIdx", i < 8 ? i : 0, rptIndex)
		end
		$display("done coprocessor");
		print_verdict();
	end
endmodule // test_mmu_register_move_decode
bind mrmd_top mrmd_monitor mon (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
	.atcFlushAll, .atcInvalidSupervisor, .atcInvalidDma, .rptInvalidate, .preloadStrobe,
	.preloadFc, .preloadAddr, .configError, .illegalInstr, .windowEnable);
